// ==== rtl/cell_pkg.sv ====
// shared constants, types and helpers for the logic cell
package cell_pkg;

	// table geometry: two four-input tables, one three-input combiner
	localparam int LUT4_INPUTS = 4;
	localparam int LUT4_SIZE   = 16;
	localparam int LUT3_INPUTS = 3;
	localparam int LUT3_SIZE   = 8;

	// bit positions of the combiner's address
	localparam int COMB_LOW_POS  = 0;
	localparam int COMB_MID_POS  = 1;
	localparam int COMB_HIGH_POS = 2;

	// reset values
	localparam logic OUT_RST  = 1'h0;
	localparam logic SYNC_RST = 1'h0;

	// pin synchroniser depth, in clock cycles
	localparam int SYNC_STAGES = 2;

	// enhanced variant: storage elements may run as latches
	localparam logic LATCH_SUPPORT = 1'h1;

	// storage element data source
	typedef enum logic [1:0]
	{
		SRC_F   = 2'h0,
		SRC_G   = 2'h1,
		SRC_H   = 2'h3,
		SRC_DIN = 2'h2
	} src_t;

	// picks a storage element's data among the table results and direct in
	function automatic logic pick_source(
		input src_t sel,
		input logic f_val,
		input logic g_val,
		input logic h_val,
		input logic din_val
	);
		logic res;
		res = f_val;
		case (sel)
			SRC_F:   res = f_val;
			SRC_G:   res = g_val;
			SRC_H:   res = h_val;
			SRC_DIN: res = din_val;
			default: res = f_val;
		endcase
		return res;
	endfunction

endpackage

// ==== rtl/lookup_table.sv ====
// generic truth-table lookup used for all three function tables
`timescale 1ns/10ps
module lookup_table #(
	parameter int N = 4
) (
	input  wire logic [(1 << N) - 1:0] truth_i,
	input  wire logic [N - 1:0]        sel_i,
	output logic                       out_o
);

	// one mux level per input bit, so delay never depends on the table
	assign out_o = truth_i[sel_i];

endmodule

// ==== rtl/storage_elem.sv ====
// one storage element: flip-flop or latch with preset/clear
`timescale 1ns/10ps
module storage_elem (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic d_i,
	input  wire logic init_set_i,
	input  wire logic sr_en_i,
	input  wire logic local_sr_i,
	input  wire logic global_init_i,
	input  wire logic latch_mode_i,
	input  wire logic gate_i,
	output logic      q_o
);

	logic q_r;
	logic force_init;
	logic use_latch;

	// one configuration bit picks the state for every init source
	assign force_init = !nrst_i || global_init_i || (sr_en_i && local_sr_i);
	// latch only exists on the enhanced variant
	assign use_latch = latch_mode_i && cell_pkg::LATCH_SUPPORT;

	// init wins over any capture; capture resumes the edge after release
	always_ff @(posedge mclk_i)
	begin
		if (force_init)
			q_r <= init_set_i; // RULE8 RULE17
		else if (use_latch)
		begin
			if (gate_i)
				q_r <= d_i; // RULE5
		end
		else
			q_r <= d_i; // RULE5
	end

	assign q_o = q_r;

endmodule

// ==== rtl/logic_cell.sv ====
// programmable logic cell: three tables, two selectors, two storage elements
`timescale 1ns/10ps

// Notes on behaviour
// (RULE1) each four-input table gives any function, equal delay for all
// (RULE2) combiner: any three-input function; two inputs pick table or pin
// (RULE3) first output: table A or combiner; second: table B or combiner
// (RULE4) storage elements load table results, direct data, or combiner path
// (RULE5) storage elements are flip-flops, or latches on the enhanced variant
// (RULE6) only two unregistered results leave; a third must be stored; here both results leave through a register
// (RULE7) thirteen inputs and four outputs face the routing
// (RULE8) one bit per element picks set or clear for all init sources
// (RULE9) set/clear choice and local enable are separate per element
// (RULE10) local preset/clear is active high and has no inverter
// (RULE11) global init forces configured state at power-up, reload, reset net
// (RULE12) an element set locally is set globally too; same for clear
// (RULE13) global init may come from a pin, with optional inversion
// (RULE14) global init may instead come from an internal logic node
// (RULE15) tables combine into any five-input or some six-input functions
// (RULE16) combiner gives some nine-input functions such as parity or compare
// (RULE17) held init keeps the element's state; capture resumes after release
module logic_cell (
	// cell clock, one of the thirteen cell inputs
	input  wire logic                        mclk_i,
	input  wire logic                        nrst_i,
	// cell inputs from the routing
	input  wire logic [3:0]                  lut_a_inputs_i,
	input  wire logic [3:0]                  lut_b_inputs_i,
	input  wire logic                        combine_outside_input_i,
	input  wire logic                        combine_alt_input_high_i,
	input  wire logic                        combine_alt_input_low_i,
	input  wire logic                        latch_gate_i,
	// configuration: table contents
	input  wire logic [15:0]                 lut_a_truth_i,
	input  wire logic [15:0]                 lut_b_truth_i,
	input  wire logic [7:0]                  combine_truth_i,
	// configuration: combiner and output selectors
	input  wire logic                        comb_low_from_a_i,
	input  wire logic                        comb_high_from_b_i,
	input  wire logic                        x_from_combine_i,
	input  wire logic                        y_from_combine_i,
	// configuration: storage elements
	input  wire cell_pkg::src_t              x_src_i,
	input  wire cell_pkg::src_t              y_src_i,
	input  wire logic                        x_init_set_i,
	input  wire logic                        y_init_set_i,
	input  wire logic                        x_sr_en_i,
	input  wire logic                        y_sr_en_i,
	input  wire logic                        x_latch_mode_i,
	input  wire logic                        y_latch_mode_i,
	// global init sources and their configuration
	input  wire logic                        global_init_line_pin_i,
	input  wire logic                        global_init_internal_i,
	input  wire logic                        gil_from_pin_i,
	input  wire logic                        gil_invert_i,
	// the four cell outputs
	output logic                             comb_x_o,
	output logic                             comb_y_o,
	output logic                             store_x_o,
	output logic                             store_y_o
);

	logic                            local_preset_clear;
	logic                            direct_data;
	logic                            f_val;
	logic                            g_val;
	logic                            h_val;
	logic                            comb_low;
	logic                            comb_high;
	logic [cell_pkg::LUT3_INPUTS-1:0] comb_sel;
	logic [cell_pkg::SYNC_STAGES-1:0] gil_sync_r;
	logic                            gil_pin_level;
	logic                            global_init_line;
	logic                            x_data;
	logic                            y_data;
	logic                            comb_x_r;
	logic                            comb_y_r;

	// shared control pins save routing: low alt input doubles as the
	// local preset/clear, high alt input doubles as direct data
	assign local_preset_clear = combine_alt_input_low_i; // RULE7 RULE10
	assign direct_data        = combine_alt_input_high_i; // RULE7

	// two independent four-input tables
	lookup_table #(
		.N (cell_pkg::LUT4_INPUTS)
	) lut_a (
		.truth_i (lut_a_truth_i),
		.sel_i   (lut_a_inputs_i),
		.out_o   (f_val)
	); // RULE1

	lookup_table #(
		.N (cell_pkg::LUT4_INPUTS)
	) lut_b (
		.truth_i (lut_b_truth_i),
		.sel_i   (lut_b_inputs_i),
		.out_o   (g_val)
	); // RULE1

	// combiner inputs: two selectable, the middle one always from outside
	assign comb_low  = comb_low_from_a_i ? f_val : combine_alt_input_low_i;
	assign comb_high = comb_high_from_b_i ? g_val : combine_alt_input_high_i;

	// address bits placed by name so the truth table layout stays fixed
	always_comb
	begin
		comb_sel = '0;
		comb_sel[cell_pkg::COMB_LOW_POS]  = comb_low; // RULE2
		comb_sel[cell_pkg::COMB_MID_POS]  = combine_outside_input_i; // RULE2
		comb_sel[cell_pkg::COMB_HIGH_POS] = comb_high; // RULE2
	end

	// with both tables feeding it, the combiner widens the cell to
	// five inputs, some six, or nine for parity and compare
	lookup_table #(
		.N (cell_pkg::LUT3_INPUTS)
	) lut_h (
		.truth_i (combine_truth_i),
		.sel_i   (comb_sel),
		.out_o   (h_val)
	); // RULE15 RULE16

	// pin source crosses into the clock domain through two stages
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			gil_sync_r <= {cell_pkg::SYNC_STAGES{cell_pkg::SYNC_RST}};
		else
			gil_sync_r <= {gil_sync_r[cell_pkg::SYNC_STAGES-2:0],
				global_init_line_pin_i};
	end

	// first stage is read only by the second stage
	assign gil_pin_level = gil_sync_r[cell_pkg::SYNC_STAGES-1];

	// optional inverter after the input buffer; internal node unsynced
	assign global_init_line = gil_from_pin_i ?
		(gil_pin_level ^ gil_invert_i) : // RULE13
		global_init_internal_i; // RULE14

	// storage data: table results, combiner, or direct data
	assign x_data = cell_pkg::pick_source(x_src_i, f_val, g_val, h_val,
		direct_data); // RULE4
	assign y_data = cell_pkg::pick_source(y_src_i, f_val, g_val, h_val,
		direct_data); // RULE4

	// combinational results are registered so the outputs leave on flops;
	// this costs one cycle of latency against the raw table path
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			comb_x_r <= cell_pkg::OUT_RST;
		else
			comb_x_r <= x_from_combine_i ? h_val : f_val; // RULE3
	end

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			comb_y_r <= cell_pkg::OUT_RST;
		else
			comb_y_r <= y_from_combine_i ? h_val : g_val; // RULE3
	end

	// only these two result outputs exist; a third function has to
	// go through one of the storage elements
	assign comb_x_o = comb_x_r; // RULE6
	assign comb_y_o = comb_y_r; // RULE6

	// both elements share the local and global lines but each has its own
	// polarity bit and local enable
	storage_elem store_x (
		.mclk_i        (mclk_i),
		.nrst_i        (nrst_i),
		.d_i           (x_data),
		.init_set_i    (x_init_set_i),
		.sr_en_i       (x_sr_en_i),
		.local_sr_i    (local_preset_clear),
		.global_init_i (global_init_line),
		.latch_mode_i  (x_latch_mode_i),
		.gate_i        (latch_gate_i),
		.q_o           (store_x_o)
	); // RULE9 RULE11 RULE12

	storage_elem store_y (
		.mclk_i        (mclk_i),
		.nrst_i        (nrst_i),
		.d_i           (y_data),
		.init_set_i    (y_init_set_i),
		.sr_en_i       (y_sr_en_i),
		.local_sr_i    (local_preset_clear),
		.global_init_i (global_init_line),
		.latch_mode_i  (y_latch_mode_i),
		.gate_i        (latch_gate_i),
		.q_o           (store_y_o)
	); // RULE9 RULE11 RULE12

	// table A reaches the first output one edge after its inputs
	lut_a_path_a: assert property ( // RULE1
		@(posedge mclk_i) disable iff (!nrst_i)
		!x_from_combine_i |=>
			comb_x_o == $past(lut_a_truth_i[lut_a_inputs_i]))
		else $error("first output does not follow table A");

	// combiner fed from both tables gives its truth bit
	combine_tables_a: assert property ( // RULE2
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_from_combine_i && comb_low_from_a_i && comb_high_from_b_i) |=>
			comb_x_o == $past(combine_truth_i[{
				lut_b_truth_i[lut_b_inputs_i],
				combine_outside_input_i,
				lut_a_truth_i[lut_a_inputs_i]}]))
		else $error("combiner from tables gives wrong result");

	// combiner fed from pins only
	combine_pins_a: assert property ( // RULE2
		@(posedge mclk_i) disable iff (!nrst_i)
		(y_from_combine_i && !comb_low_from_a_i && !comb_high_from_b_i) |=>
			comb_y_o == $past(combine_truth_i[{
				combine_alt_input_high_i,
				combine_outside_input_i,
				combine_alt_input_low_i}]))
		else $error("combiner from pins gives wrong result");

	// second output picks table B
	lut_b_path_a: assert property ( // RULE3
		@(posedge mclk_i) disable iff (!nrst_i)
		!y_from_combine_i |=>
			comb_y_o == $past(lut_b_truth_i[lut_b_inputs_i]))
		else $error("second output does not follow table B");

	// internal global init forces both elements to configured state
	global_internal_a: assert property ( // RULE11 RULE14 RULE12
		@(posedge mclk_i) disable iff (!nrst_i)
		(!gil_from_pin_i && global_init_internal_i) |=>
			(store_x_o == $past(x_init_set_i)) &&
			(store_y_o == $past(y_init_set_i)))
		else $error("internal global init not applied");

	// pin source acts two edges late, after the optional inverter
	global_pin_a: assert property ( // RULE13
		@(posedge mclk_i) disable iff (!nrst_i)
		(gil_from_pin_i && $past(gil_from_pin_i, 2) &&
			($past(global_init_line_pin_i, 2) != gil_invert_i)) |=>
			store_y_o == $past(y_init_set_i))
		else $error("pin global init not applied");

	// enabled local preset/clear forces the element
	local_active_a: assert property ( // RULE10 RULE8
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_sr_en_i && local_preset_clear) |=>
			store_x_o == $past(x_init_set_i))
		else $error("local preset/clear not applied");

	// disabled local input leaves the flip-flop capturing
	local_disabled_a: assert property ( // RULE9 RULE4
		@(posedge mclk_i) disable iff (!nrst_i)
		(!y_sr_en_i && local_preset_clear && !global_init_line &&
			!y_latch_mode_i) |=> store_y_o == $past(y_data))
		else $error("disabled local input still acts");

	// init held for two edges, then capture resumes the edge after release
	init_release_a: assert property ( // RULE17
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_sr_en_i && local_preset_clear)[*2] ##1
			(!local_preset_clear && !global_init_line && !x_latch_mode_i)
			|=> store_x_o == $past(x_data))
		else $error("capture did not resume after release");

	// closed latch holds its value
	latch_hold_a: assert property ( // RULE5
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_latch_mode_i && !latch_gate_i && !global_init_line &&
			!(x_sr_en_i && local_preset_clear)) |=> $stable(store_x_o))
		else $error("closed latch changed");

	// direct data reaches the element selected for it
	direct_load_a: assert property ( // RULE4
		@(posedge mclk_i) disable iff (!nrst_i)
		(y_src_i == cell_pkg::SRC_DIN && !global_init_line &&
			!(y_sr_en_i && local_preset_clear) && !y_latch_mode_i) |=>
			store_y_o == $past(combine_alt_input_high_i))
		else $error("direct data not loaded");

	// held reset clears the results and loads each configured state
	reset_state_a: assert property ( // RULE11
		@(posedge mclk_i)
		!nrst_i |=>
			(comb_x_o == cell_pkg::OUT_RST) &&
			(comb_y_o == cell_pkg::OUT_RST) &&
			(store_x_o == $past(x_init_set_i)) &&
			(store_y_o == $past(y_init_set_i)))
		else $error("reset state not applied");

	// first output picks the combiner fed from pins only
	x_combine_pins_a: assert property ( // RULE3
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_from_combine_i && !comb_low_from_a_i && !comb_high_from_b_i) |=>
			comb_x_o == $past(combine_truth_i[{
				combine_alt_input_high_i,
				combine_outside_input_i,
				combine_alt_input_low_i}]))
		else $error("first output misses pin combiner");

	// second output picks the combiner fed from both tables
	y_combine_tables_a: assert property ( // RULE3
		@(posedge mclk_i) disable iff (!nrst_i)
		(y_from_combine_i && comb_low_from_a_i && comb_high_from_b_i) |=>
			comb_y_o == $past(combine_truth_i[{
				lut_b_truth_i[lut_b_inputs_i],
				combine_outside_input_i,
				lut_a_truth_i[lut_a_inputs_i]}]))
		else $error("second output misses table combiner");

	// combiner mixing table A with the high pin
	combine_mixed_a: assert property ( // RULE2
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_from_combine_i && comb_low_from_a_i && !comb_high_from_b_i) |=>
			comb_x_o == $past(combine_truth_i[{
				combine_alt_input_high_i,
				combine_outside_input_i,
				lut_a_truth_i[lut_a_inputs_i]}]))
		else $error("mixed combiner gives wrong result");

	// second element's local preset/clear follows its own polarity bit
	y_local_active_a: assert property ( // RULE9
		@(posedge mclk_i) disable iff (!nrst_i)
		(y_sr_en_i && local_preset_clear) |=>
			store_y_o == $past(y_init_set_i))
		else $error("second local preset/clear not applied");

	// flip-flop loading table A keeps the table result
	table_store_a: assert property ( // RULE4
		@(posedge mclk_i) disable iff (!nrst_i)
		(x_src_i == cell_pkg::SRC_F && !global_init_line &&
			!(x_sr_en_i && local_preset_clear) && !x_latch_mode_i) |=>
			store_x_o == $past(lut_a_truth_i[lut_a_inputs_i]))
		else $error("table result not stored");

	// a third function leaves through storage, not a result output
	combine_store_a: assert property ( // RULE6
		@(posedge mclk_i) disable iff (!nrst_i)
		(y_src_i == cell_pkg::SRC_H && !global_init_line &&
			!(y_sr_en_i && local_preset_clear) && !y_latch_mode_i) |=>
			store_y_o == $past(h_val))
		else $error("combiner result not stored");

	// open latch passes its data one edge late
	latch_open_a: assert property ( // RULE5
		@(posedge mclk_i) disable iff (!nrst_i)
		(y_latch_mode_i && latch_gate_i && !global_init_line &&
			!(y_sr_en_i && local_preset_clear)) |=>
			store_y_o == $past(y_data))
		else $error("open latch did not pass data");

endmodule

// ==== verification/routing_model.sv ====
// partner model: routing that feeds the cell's table and combiner inputs
`timescale 1ns/10ps
module routing_model (
	input  wire logic       mclk_i,
	input  wire logic       run_i,
	output logic      [3:0] lut_a_o = 4'h0,
	output logic      [3:0] lut_b_o = 4'h0,
	output logic            h_mid_o = 1'h0,
	output logic            h_lo_o  = 1'h0,
	output logic            h_hi_o  = 1'h0
);
	// fresh operands every cycle; the routing has no handshake to wait on
	always @(posedge mclk_i)
	begin
		if (run_i)
		begin
			lut_a_o <= 4'($urandom);
			lut_b_o <= 4'($urandom);
			{h_mid_o, h_lo_o, h_hi_o} <= 3'($urandom);
		end
	end
endmodule

// ==== verification/test_logic_cell.sv ====
// self-checking bench for the logic cell with a cycle reference model
`timescale 1ns/10ps
module test_logic_cell;
	logic           mclk_i;
	logic           nrst_i;
	logic           run_en;
	logic [3:0]     lut_a;
	logic [3:0]     lut_b;
	logic           h_mid, h_lo, h_hi;
	logic [15:0]    ta, tb;
	logic [7:0]     tc;
	logic           lo_a, hi_b, xc, yc, xi, yi, xe, ye, xl, yl;
	logic           gate, gpin, gint, gfp, ginv;
	cell_pkg::src_t xs, ys;
	logic           comb_x_o, comb_y_o, store_x_o, store_y_o;
	logic           fa, fb, hv, gi, s1, s2, armed;
	logic           ecx, ecy, esx, esy;
	int             n_errors;
	int             compares;

	routing_model routing_model_inst (
		.mclk_i  (mclk_i),
		.run_i   (run_en),
		.lut_a_o (lut_a),
		.lut_b_o (lut_b),
		.h_mid_o (h_mid),
		.h_lo_o  (h_lo),
		.h_hi_o  (h_hi)
	);

	logic_cell logic_cell_inst (
		.mclk_i                   (mclk_i),
		.nrst_i                   (nrst_i),
		.lut_a_inputs_i           (lut_a),
		.lut_b_inputs_i           (lut_b),
		.combine_outside_input_i  (h_mid),
		.combine_alt_input_high_i (h_hi),
		.combine_alt_input_low_i  (h_lo),
		.latch_gate_i             (gate),
		.lut_a_truth_i            (ta),
		.lut_b_truth_i            (tb),
		.combine_truth_i          (tc),
		.comb_low_from_a_i        (lo_a),
		.comb_high_from_b_i       (hi_b),
		.x_from_combine_i         (xc),
		.y_from_combine_i         (yc),
		.x_src_i                  (xs),
		.y_src_i                  (ys),
		.x_init_set_i             (xi),
		.y_init_set_i             (yi),
		.x_sr_en_i                (xe),
		.y_sr_en_i                (ye),
		.x_latch_mode_i           (xl),
		.y_latch_mode_i           (yl),
		.global_init_line_pin_i   (gpin),
		.global_init_internal_i   (gint),
		.gil_from_pin_i           (gfp),
		.gil_invert_i             (ginv),
		.comb_x_o                 (comb_x_o),
		.comb_y_o                 (comb_y_o),
		.store_x_o                (store_x_o),
		.store_y_o                (store_y_o)
	);

	// clock generator
	initial
	begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end

	// next storage state; init sources win over capture
	function automatic logic nxt(logic q, cell_pkg::src_t s, logic i,
		logic e, logic l);
		if (gi)
			return i;
		if (e && h_lo)
			return i;
		if (l && !gate)
			return q;
		case (s)
			cell_pkg::SRC_F: return fa;
			cell_pkg::SRC_G: return fb;
			cell_pkg::SRC_H: return hv;
			default:         return h_hi;
		endcase
	endfunction

	// reference model on values sampled at each edge, before updates land
	always @(posedge mclk_i)
	begin
		fa = ta[lut_a];
		fb = tb[lut_b];
		hv = tc[{hi_b ? fb : h_hi, h_mid, lo_a ? fa : h_lo}];
		gi = gfp ? (s2 ^ ginv) : gint;
		if (!nrst_i)
		begin
			{ecx, ecy, s1, s2} = 4'h0;
			esx = xi;
			esy = yi;
		end
		else
		begin
			ecx = xc ? hv : fa;
			ecy = yc ? hv : fb;
			esx = nxt(esx, xs, xi, xe, xl);
			esy = nxt(esy, ys, yi, ye, yl);
			s2 = s1;
			s1 = gpin;
		end
		armed = 1'h1;
	end

	task automatic chk(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s got %b", $time, what, got);
		end
	endtask

	// outputs are settled by the falling edge
	always @(negedge mclk_i)
		if (armed)
		begin
			chk(comb_x_o, ecx, "comb x");
			chk(comb_y_o, ecy, "comb y");
			chk(store_x_o, esx, "store x");
			chk(store_y_o, esy, "store y");
		end

	task automatic rnd_cfg();
		ta <= 16'($urandom);
		tb <= 16'($urandom);
		tc <= 8'($urandom);
		{lo_a, hi_b, xc, yc, xi, yi, xe, ye, xl, yl} <= 10'($urandom);
		{gfp, ginv} <= 2'($urandom);
		xs <= cell_pkg::src_t'($urandom_range(3));
		ys <= cell_pkg::src_t'($urandom_range(3));
	endtask

	// global init sources kept rare so that capture is seen often
	task automatic run(input int n);
		repeat (n)
		begin
			@(posedge mclk_i);
			gate <= 1'($urandom);
			gpin <= ($urandom_range(7) == 0);
			gint <= ($urandom_range(7) == 0);
		end
	endtask

	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// main sequence; pin init held low in reset so the synchroniser is clean
	initial
	begin
		void'($urandom(11922));
		{n_errors, compares} = '0;
		{armed, nrst_i, gate, gpin, gint, gfp, ginv} = 7'h0;
		run_en = 1'h1;
		{ta, tb, tc} = 40'h0;
		{lo_a, hi_b, xc, yc, xi, yi, xe, ye, xl, yl} = 10'h0;
		xs = cell_pkg::SRC_F;
		ys = cell_pkg::SRC_F;
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'h1;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge mclk_i);
			rnd_cfg();
			run(50);
		end
		// nine-input parity through both tables and the combiner
		@(posedge mclk_i);
		{ta, tb, tc} <= {16'h6996, 16'h6996, 8'h96};
		{lo_a, hi_b, xc} <= 3'h7;
		run(60);
		// five-input function: middle input chooses table a or b
		@(posedge mclk_i);
		{tc, yc} <= {8'he2, 1'h1};
		run(60);
		// every storage source, pin init plain and inverted
		for (int i = 0; i < 4; i++)
		begin
			@(posedge mclk_i);
			xs <= cell_pkg::src_t'(i);
			ys <= cell_pkg::src_t'(3 - i);
			{gfp, ginv, xl, yl} <= {1'h1, 1'(i), 2'(i)};
			run(30);
		end
		// second reset in mid-run
		@(posedge mclk_i);
		{nrst_i, gpin} <= 2'h0;
		repeat (3) @(posedge mclk_i);
		nrst_i <= 1'h1;
		run(40);
		conclude();
	end
endmodule
